// ---- design/ccs_defines.vh ----
// constants for the carrier control/status register group
// assumes word-indexed register offsets as seen on the local register port
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH

// register offsets (word index on the register port)
`define CCS_ADDR_W 10
`define CCS_OFS_ENGINE 10'h340
`define CCS_OFS_INTCTL 10'h341
`define CCS_OFS_SLOTINFO 10'h380

// engine control word fields
`define CCS_CTL_CLR_ABORT 0
`define CCS_CTL_ENABLE 1
`define CCS_CTL_ENG_RESET 2

// engine status word fields
`define CCS_ST_ABORT 0
`define CCS_ST_ENABLE 1
`define CCS_ST_MM_INT 2
`define CCS_ST_SW_INT 3
`define CCS_ST_FWR_LSB 4
`define CCS_ST_FRD_LSB 10
`define CCS_ST_RDQ_LSB 16
`define CCS_ST_WRQ_LSB 22

// interrupt control word fields
`define CCS_IC_MM_MASK 2
`define CCS_IC_SW_INT 3

// slot information word fields
`define CCS_SI_SLOT_W 25
`define CCS_SI_CONFIG 27
`define CCS_SI_ID_LSB 28

// reset values
`define CCS_CTL_RST 3'h0
`define CCS_IC_RST 2'h0

// queue sizing
`define CCS_NUM_FIFO 6
`define CCS_QUEUE_DEPTH 4

`endif

// ---- design/ccs_pin_sync.v ----
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pins; the stable copy updates when stages two and three agree
`timescale 1ns/1ps
module ccs_pin_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire i_ref_clk,
    input wire i_rstn,
    input wire [WIDTH-1:0] i_pin,
    output reg [WIDTH-1:0] o_stable_ff
);
    reg [WIDTH-1:0] s1_ff; // first stage, read only by s2
    reg [WIDTH-1:0] s2_ff; // second stage
    reg [WIDTH-1:0] s3_ff; // third stage
    reg [WIDTH-1:0] nxt_stable;
    integer k;

    // per bit: accept a change only once two settled stages agree
    always @* begin
        nxt_stable = o_stable_ff;
        for (k = 0; k < WIDTH; k = k + 1) begin
            if (s2_ff[k] == s3_ff[k]) begin
                nxt_stable[k] = s2_ff[k];
            end
        end
    end

    // shift chain and filtered copy
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
            o_stable_ff <= RST_VAL;
        end else begin
            s1_ff <= i_pin;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            o_stable_ff <= nxt_stable;
        end
    end
endmodule

// ---- design/ccs_queue_track.v ----
// occupancy trackers for a set of master-mode transfer queues
// assumes push/pop pulses from the queue engine on the same clock
`timescale 1ns/1ps
`include "ccs_defines.vh"
module ccs_queue_track #(
    parameter NUM = `CCS_NUM_FIFO,
    parameter DEPTH = `CCS_QUEUE_DEPTH
) (
    input wire i_ref_clk,
    input wire i_rstn,
    input wire i_flush,
    input wire [NUM-1:0] i_push,
    input wire [NUM-1:0] i_pop,
    output wire [NUM-1:0] o_full
);
    localparam [2:0] DEPTH_C = DEPTH[2:0];

    genvar g;
    generate
        for (g = 0; g < NUM; g = g + 1) begin : g_q
            reg [2:0] cnt_ff; // pending transfers in this queue
            reg [2:0] nxt_cnt;
            wire full = (cnt_ff == DEPTH_C);
            wire do_push = i_push[g] & ~full; // a push into a full queue is dropped
            wire do_pop = i_pop[g] & (cnt_ff != 3'h0);

            // count next value; flush empties the queue outright
            always @* begin
                nxt_cnt = cnt_ff;
                if (i_flush) begin
                    nxt_cnt = 3'h0;
                end else if (do_push & ~do_pop) begin
                    nxt_cnt = cnt_ff + 3'h1;
                end else if (do_pop & ~do_push) begin
                    nxt_cnt = cnt_ff - 3'h1;
                end
            end

            always @(posedge i_ref_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    cnt_ff <= 3'h0;
                end else begin
                    cnt_ff <= nxt_cnt;
                end
            end

            assign o_full[g] = full; // at most DEPTH entries
        end
    endgenerate
endmodule

// ---- design/ccs_regs.v ----
// control, status, interrupt and slot information registers of the carrier
// assumes the PCI target decodes accesses to word-indexed offsets and gives
// one-cycle read/write strobes; the queue engine gives pulses on this clock
// limitation: FIFO interrupt causes are levels that are not latched here, so the
// FIFO blocks must hold a cause until software has serviced it
`timescale 1ns/1ps
`include "ccs_defines.vh"
module ccs_regs #(
    parameter NUM_FIFO = `CCS_NUM_FIFO,
    parameter QUEUE_DEPTH = `CCS_QUEUE_DEPTH
) (
    input wire i_ref_clk,
    input wire i_rstn,
    input wire [`CCS_ADDR_W-1:0] i_reg_addr,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [31:0] i_reg_wdata,
    output reg [31:0] o_reg_rdata_ff,
    output reg o_reg_rvalid_ff,
    input wire i_mst_abort,
    input wire i_mst_done,
    input wire i_mm_int_reg_rd,
    input wire [NUM_FIFO-1:0] i_fifo_wr_int,
    input wire [NUM_FIFO-1:0] i_fifo_rd_int,
    input wire [NUM_FIFO-1:0] i_rdq_push,
    input wire [NUM_FIFO-1:0] i_rdq_pop,
    input wire [NUM_FIFO-1:0] i_wrq_push,
    input wire [NUM_FIFO-1:0] i_wrq_pop,
    input wire [`CCS_SI_SLOT_W-1:0] i_slot_info,
    input wire i_config_n,
    input wire [3:0] i_carrier_id,
    output reg o_mst_permit_ff,
    output reg o_eng_reset_ff,
    output reg o_irq_ff,
    output reg o_inta_n_o_ff,
    output reg o_inta_n_oe_ff
);
    // control word storage
    reg clr_abort_ff; // clear-abort control bit
    reg enable_ff; // global master transfer enable
    reg eng_reset_ff; // engine reset control bit
    // interrupt control word storage
    reg mm_mask_ff; // completion interrupt enable
    reg sw_int_ff; // software interrupt request
    // hardware status flags
    reg abort_ff; // master abort received
    reg mm_int_ff; // transfer completion pending
    reg [NUM_FIFO-1:0] fwr_int_ff; // registered FIFO write interrupts
    reg [NUM_FIFO-1:0] frd_int_ff; // registered FIFO read interrupts

    reg nxt_clr_abort;
    reg nxt_enable;
    reg nxt_eng_reset;
    reg nxt_mm_mask;
    reg nxt_sw_int;
    reg nxt_abort;
    reg nxt_mm_int;
    reg [31:0] nxt_rdata;
    reg [31:0] status_word;
    reg [31:0] intctl_word;
    reg [31:0] slot_word;

    wire [NUM_FIFO-1:0] rdq_full;
    wire [NUM_FIFO-1:0] wrq_full;
    wire [`CCS_SI_SLOT_W-1:0] slot_stable;
    wire config_stable_n;
    wire [3:0] id_stable;
    wire irq_any;

    // offset match, shared by both write decodes
    function ccs_addr_hit;
        input [`CCS_ADDR_W-1:0] addr;
        input [`CCS_ADDR_W-1:0] ofs;
        begin
            ccs_addr_hit = (addr == ofs);
        end
    endfunction

    // decoded write strobes
    wire wr_engine = i_reg_wr & ccs_addr_hit(i_reg_addr, `CCS_OFS_ENGINE);
    wire wr_intctl = i_reg_wr & ccs_addr_hit(i_reg_addr, `CCS_OFS_INTCTL);
    // the flag clears only on the 1->0 step, so a driver that leaves the bit at one
    // keeps transfers blocked; this matches the one-then-zero recovery sequence
    // falling edge of the clear-abort bit finishes the recovery handshake
    wire clr_abort_fall = clr_abort_ff & ~nxt_clr_abort;

    // read and write queue occupancy
    // both directions share one flush: engine reset empties every queue at once
    ccs_queue_track #(
        .NUM(NUM_FIFO),
        .DEPTH(QUEUE_DEPTH)
    ) u_rdq (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_flush(eng_reset_ff),
        .i_push(i_rdq_push),
        .i_pop(i_rdq_pop),
        .o_full(rdq_full)
    );

    ccs_queue_track #(
        .NUM(NUM_FIFO),
        .DEPTH(QUEUE_DEPTH)
    ) u_wrq (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_flush(eng_reset_ff),
        .i_push(i_wrq_push),
        .i_pop(i_wrq_pop),
        .o_full(wrq_full)
    );

    // trade-off: three stages delay strap changes by a few cycles, which software
    // never notices, in exchange for a copy that cannot go metastable
    // board straps arrive from pins; reset values are the idle "not fitted" sense
    ccs_pin_sync #(
        .WIDTH(`CCS_SI_SLOT_W + 5),
        .RST_VAL({(`CCS_SI_SLOT_W + 5){1'b1}})
    ) u_pins (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_pin({i_carrier_id, i_config_n, i_slot_info}),
        .o_stable_ff({id_stable, config_stable_n, slot_stable})
    );

    // control word next state; bits above 2 are not stored at all
    always @* begin
        nxt_clr_abort = clr_abort_ff;
        nxt_enable = enable_ff;
        nxt_eng_reset = eng_reset_ff;
        if (wr_engine) begin
            nxt_clr_abort = i_reg_wdata[`CCS_CTL_CLR_ABORT];
            nxt_enable = i_reg_wdata[`CCS_CTL_ENABLE];
            nxt_eng_reset = i_reg_wdata[`CCS_CTL_ENG_RESET];
        end
    end

    // only bits 2 and 3 are stored; every other bit reads back as zero
    // interrupt control word next state
    always @* begin
        nxt_mm_mask = mm_mask_ff;
        nxt_sw_int = sw_int_ff;
        if (wr_intctl) begin
            nxt_mm_mask = i_reg_wdata[`CCS_IC_MM_MASK];
            nxt_sw_int = i_reg_wdata[`CCS_IC_SW_INT]; // stays until software clears
        end
    end

    // both flags are sticky; a status read alone never clears them
    // sticky status flags; a new event in the clearing cycle wins
    always @* begin
        nxt_abort = abort_ff;
        if (clr_abort_fall) begin
            nxt_abort = 1'b0;
        end
        if (i_mst_abort) begin
            nxt_abort = 1'b1;
        end
        nxt_mm_int = mm_int_ff;
        if (i_mm_int_reg_rd) begin
            nxt_mm_int = 1'b0;
        end
        if (i_mst_done) begin
            nxt_mm_int = 1'b1;
        end
    end

    // status word assembly, unused upper bits read zero
    always @* begin
        status_word = 32'h0000_0000;
        status_word[`CCS_ST_ABORT] = abort_ff;
        status_word[`CCS_ST_ENABLE] = enable_ff;
        status_word[`CCS_ST_MM_INT] = mm_int_ff;
        status_word[`CCS_ST_SW_INT] = sw_int_ff;
        status_word[`CCS_ST_FWR_LSB +: NUM_FIFO] = fwr_int_ff;
        status_word[`CCS_ST_FRD_LSB +: NUM_FIFO] = frd_int_ff;
        status_word[`CCS_ST_RDQ_LSB +: NUM_FIFO] = rdq_full;
        status_word[`CCS_ST_WRQ_LSB +: NUM_FIFO] = wrq_full;
    end

    // interrupt control readback, other bits zero
    always @* begin
        intctl_word = 32'h0000_0000;
        intctl_word[`CCS_IC_MM_MASK] = mm_mask_ff;
        intctl_word[`CCS_IC_SW_INT] = sw_int_ff;
    end

    // slot info: pin sense is passed as is, so low means fitted etc.
    always @* begin
        slot_word = 32'h0000_0000;
        slot_word[`CCS_SI_SLOT_W-1:0] = slot_stable;
        slot_word[`CCS_SI_CONFIG] = config_stable_n;
        slot_word[`CCS_SI_ID_LSB +: 4] = id_stable;
    end

    // writes to the slot word or unmapped offsets fall through and change nothing
    // read mux; unmapped offsets answer zero
    always @* begin
        case (i_reg_addr)
            `CCS_OFS_ENGINE: nxt_rdata = status_word;
            `CCS_OFS_INTCTL: nxt_rdata = intctl_word;
            `CCS_OFS_SLOTINFO: nxt_rdata = slot_word;
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    // one line from all sources; the completion source is gated by its mask
    assign irq_any = (mm_int_ff & mm_mask_ff) | sw_int_ff | (|fwr_int_ff) | (|frd_int_ff);

    // control and interrupt words: cleared by bus reset
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            clr_abort_ff <= 1'b0;
            enable_ff <= 1'b0;
            eng_reset_ff <= 1'b0;
            mm_mask_ff <= 1'b0;
            sw_int_ff <= 1'b0;
        end else begin
            clr_abort_ff <= nxt_clr_abort;
            enable_ff <= nxt_enable;
            eng_reset_ff <= nxt_eng_reset;
            mm_mask_ff <= nxt_mm_mask;
            sw_int_ff <= nxt_sw_int;
        end
    end

    // status flags; FIFO causes are registered to keep the line glitch free
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            abort_ff <= 1'b0;
            mm_int_ff <= 1'b0;
            fwr_int_ff <= {NUM_FIFO{1'b0}};
            frd_int_ff <= {NUM_FIFO{1'b0}};
        end else begin
            abort_ff <= nxt_abort;
            mm_int_ff <= nxt_mm_int;
            fwr_int_ff <= i_fifo_wr_int;
            frd_int_ff <= i_fifo_rd_int;
        end
    end

    // permit is taken from next-state values so it drops on the same edge that
    // registers an abort, leaving no cycle in which a new transfer could start
    // engine controls: permit needs enable, no abort pending and no reset
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_mst_permit_ff <= 1'b0;
            o_eng_reset_ff <= 1'b0;
        end else begin
            o_mst_permit_ff <= nxt_enable & ~nxt_abort & ~nxt_eng_reset;
            o_eng_reset_ff <= nxt_eng_reset; // aborts transfer in flight
        end
    end

    // the pin data is tied low and only the enable toggles, which lets the line
    // be shared with other wire-ORed sources on the bus
    // interrupt line: open drain, only ever pulled low
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_irq_ff <= 1'b0;
            o_inta_n_o_ff <= 1'b0;
            o_inta_n_oe_ff <= 1'b0;
        end else begin
            o_irq_ff <= irq_any;
            o_inta_n_o_ff <= 1'b0;
            o_inta_n_oe_ff <= irq_any;
        end
    end

    // read data are held after the strobe so a slow host may sample them late
    // registered read answer one cycle after the strobe
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reg_rdata_ff <= 32'h0000_0000;
            o_reg_rvalid_ff <= 1'b0;
        end else begin
            o_reg_rvalid_ff <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata_ff <= nxt_rdata;
            end
        end
    end
endmodule

// ---- testbench/ccs_regs_monitor.sv ----
// concurrent checks on the carrier control/status register ports
// assumes it is bound onto ccs_regs and sees only that module's ports
`timescale 1ns/1ps
`include "ccs_defines.vh"
module ccs_regs_monitor #(
    parameter NUM_FIFO = 6,
    parameter QUEUE_DEPTH = 4
) (
    input wire i_ref_clk,
    input wire i_rstn,
    input wire [`CCS_ADDR_W-1:0] i_reg_addr,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [31:0] i_reg_wdata,
    input wire [31:0] o_reg_rdata_ff,
    input wire o_reg_rvalid_ff,
    input wire i_mst_abort,
    input wire [NUM_FIFO-1:0] i_fifo_wr_int,
    input wire [NUM_FIFO-1:0] i_fifo_rd_int,
    input wire o_mst_permit_ff,
    input wire o_eng_reset_ff,
    input wire o_irq_ff,
    input wire o_inta_n_o_ff,
    input wire o_inta_n_oe_ff
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rstn);
    // decoded strobes, kept apart so each property stays short
    wire wr_eng = i_reg_wr && (i_reg_addr == `CCS_OFS_ENGINE);
    wire rd_eng = i_reg_rd && (i_reg_addr == `CCS_OFS_ENGINE);
    wire rd_ic = i_reg_rd && (i_reg_addr == `CCS_OFS_INTCTL);
    wire rd_si = i_reg_rd && (i_reg_addr == `CCS_OFS_SLOTINFO);
    wire wr_ic = i_reg_wr && (i_reg_addr == `CCS_OFS_INTCTL);
    wire any_fifo = |{i_fifo_wr_int, i_fifo_rd_int};
    a_rvalid_pulse: assert property (i_reg_rd |=> o_reg_rvalid_ff)
        else $error("read gave no valid strobe");
    a_abort_blocks: assert property (i_mst_abort |=> !o_mst_permit_ff)
        else $error("transfers still permitted after abort");
    a_enable_off: assert property (wr_eng && !i_reg_wdata[1] |=> !o_mst_permit_ff)
        else $error("permit stayed with enable low");
    a_engine_reset: assert property (wr_eng && i_reg_wdata[2]
        |=> !o_mst_permit_ff ##[0:1] o_eng_reset_ff)
        else $error("engine reset not applied");
    a_sw_line: assert property (wr_ic && i_reg_wdata[3] |=> ##[0:2] o_irq_ff)
        else $error("software interrupt did not raise line");
    a_status_top: assert property (rd_eng |=> o_reg_rdata_ff[31:28] == 4'h0)
        else $error("status top bits not zero");
    a_intctl_zero: assert property (rd_ic |=> o_reg_rdata_ff[31:4] == 28'h0
        && o_reg_rdata_ff[1:0] == 2'h0)
        else $error("interrupt word spare bits not zero");
    a_slot_gap: assert property (rd_si |=> o_reg_rdata_ff[26:25] == 2'h0)
        else $error("slot word bits 25-26 not zero");
    a_line_drive: assert property (o_inta_n_oe_ff == o_irq_ff && !o_inta_n_o_ff)
        else $error("interrupt pin drive disagrees with request");
    a_fifo_line: assert property (any_fifo [*3] |-> o_irq_ff)
        else $error("fifo interrupt did not raise line");
    c_abort: cover property (i_mst_abort ##1 !o_mst_permit_ff);
    c_engine_reset: cover property (o_eng_reset_ff);
    c_irq: cover property ($rose(o_irq_ff));
endmodule
bind ccs_regs ccs_regs_monitor #(.NUM_FIFO(NUM_FIFO), .QUEUE_DEPTH(QUEUE_DEPTH)) mon_u (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata_ff(o_reg_rdata_ff),
    .o_reg_rvalid_ff(o_reg_rvalid_ff), .i_mst_abort(i_mst_abort),
    .i_fifo_wr_int(i_fifo_wr_int), .i_fifo_rd_int(i_fifo_rd_int),
    .o_mst_permit_ff(o_mst_permit_ff), .o_eng_reset_ff(o_eng_reset_ff), .o_irq_ff(o_irq_ff),
    .o_inta_n_o_ff(o_inta_n_o_ff), .o_inta_n_oe_ff(o_inta_n_oe_ff));

// ---- testbench/ccs_host_model.sv ----
// host-side model: register cycles as the host driver issues them
// assumes one-cycle strobes and read data that holds until the next read
`timescale 1ns/1ps
module ccs_host_model (
    input wire i_ref_clk,
    input wire [31:0] i_rdata,
    output logic [9:0] o_addr,
    output logic o_wr,
    output logic o_rd,
    output logic [31:0] o_wdata
);
    initial begin
        o_addr = 10'h000;
        o_wr = 1'h0;
        o_rd = 1'h0;
        o_wdata = 32'h0;
    end
    // strobe spans one edge; released lines are scrambled so stale values never look valid
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(negedge i_ref_clk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'h1;
        @(negedge i_ref_clk);
        o_wr = 1'h0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask
    // read data is taken once the strobe edge has passed
    task automatic rd(input logic [9:0] a, output logic [31:0] d);
        @(negedge i_ref_clk);
        o_addr = a;
        o_rd = 1'h1;
        @(negedge i_ref_clk);
        o_rd = 1'h0;
        o_addr = ~a;
        d = i_rdata;
    endtask
    // abort recovery: one then zero on the clear bit, other bits kept
    task automatic clr_abort(input logic [31:0] keep);
        wr(10'h340, keep | 32'h1);
        wr(10'h340, keep & ~32'h1);
    endtask
    // service routine drops the software interrupt, keeping the mask
    task automatic isr_clear(input logic [31:0] keep);
        wr(10'h341, keep & ~32'h8);
    endtask
endmodule

// ---- testbench/ccs_regs_tb.sv ----
// self-checking bench for the carrier control/status registers
// assumes the host model drives the register port; engine events come from here
`timescale 1ns/1ps
module ccs_regs_tb;
    typedef struct {logic [9:0] wa; logic [31:0] wd; logic [9:0] ra;
        logic [31:0] m; logic [31:0] e;} ccs_row_t;
    logic i_ref_clk = 1'h0;
    logic i_rstn = 1'h0;
    logic [9:0] i_reg_addr;
    logic i_reg_wr, i_reg_rd, o_reg_rvalid_ff;
    logic [31:0] i_reg_wdata, o_reg_rdata_ff, d;
    logic i_mst_abort = 1'h0, i_mst_done = 1'h0, i_mm_int_reg_rd = 1'h0;
    logic [5:0] i_fifo_wr_int = 6'h0, i_fifo_rd_int = 6'h0, i_rdq_push = 6'h0;
    logic [5:0] i_rdq_pop = 6'h0, i_wrq_push = 6'h0, i_wrq_pop = 6'h0;
    logic [24:0] i_slot_info = 25'h0A5C3E1;
    logic i_config_n = 1'h0;
    logic [3:0] i_carrier_id = 4'h9;
    logic o_mst_permit_ff, o_eng_reset_ff, o_irq_ff, o_inta_n_o_ff, o_inta_n_oe_ff;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    ccs_row_t rows [7];
    ccs_host_model host_u (.i_ref_clk(i_ref_clk), .i_rdata(o_reg_rdata_ff),
        .o_addr(i_reg_addr), .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_wdata(i_reg_wdata));
    ccs_regs dut_u (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata_ff(o_reg_rdata_ff), .o_reg_rvalid_ff(o_reg_rvalid_ff),
        .i_mst_abort(i_mst_abort), .i_mst_done(i_mst_done), .i_mm_int_reg_rd(i_mm_int_reg_rd),
        .i_fifo_wr_int(i_fifo_wr_int), .i_fifo_rd_int(i_fifo_rd_int), .i_rdq_push(i_rdq_push),
        .i_rdq_pop(i_rdq_pop), .i_wrq_push(i_wrq_push), .i_wrq_pop(i_wrq_pop),
        .i_slot_info(i_slot_info), .i_config_n(i_config_n), .i_carrier_id(i_carrier_id),
        .o_mst_permit_ff(o_mst_permit_ff), .o_eng_reset_ff(o_eng_reset_ff), .o_irq_ff(o_irq_ff),
        .o_inta_n_o_ff(o_inta_n_o_ff), .o_inta_n_oe_ff(o_inta_n_oe_ff));
    initial forever #5 i_ref_clk = ~i_ref_clk;
    // hang guard, far above the roughly 150 cycles the sequence needs
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    task automatic rdc(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
        host_u.rd(a, d);
        chk("read valid", o_reg_rvalid_ff, 32'h1);
        chk("read", d & m, e);
    endtask
    // one-cycle event: 0-5 rd push, 6-11 wr push, 12 abort, 13 done, 14 irq read, 15-20 rd pop
    task automatic pulse(input int idx);
        @(negedge i_ref_clk);
        {i_wrq_pop, i_rdq_pop, i_mm_int_reg_rd, i_mst_done, i_mst_abort, i_wrq_push,
            i_rdq_push} = 27'h1 << idx;
        @(negedge i_ref_clk);
        {i_wrq_pop, i_rdq_pop, i_mm_int_reg_rd, i_mst_done, i_mst_abort, i_wrq_push,
            i_rdq_push} = 27'h0;
    endtask
    initial begin
        rows[0] = '{10'h340, 32'h2, 10'h340, 32'h2, 32'h2};
        rows[1] = '{10'h340, 32'hFFFFFFF8, 10'h340, 32'h7, 32'h0};
        rows[2] = '{10'h341, 32'hFFFFFFFF, 10'h341, 32'hFFFFFFFF, 32'hC};
        rows[3] = '{10'h3FF, 32'hFFFFFFFF, 10'h340, 32'h8, 32'h8};
        rows[4] = '{10'h341, 32'h0, 10'h341, 32'hFFFFFFFF, 32'h0};
        rows[5] = '{10'h380, 32'h0, 10'h380, 32'hFFFFFFFF, 32'h90A5C3E1};
        rows[6] = '{10'h340, 32'h2, 10'h3FF, 32'hFFFFFFFF, 32'h0};
        cyc(6);
        i_rstn = 1'h1;
        cyc(8);
        rdc(10'h340, 32'hFFFFFFFF, 32'h0);
        rdc(10'h341, 32'hFFFFFFFF, 32'h0);
        foreach (rows[i]) begin
            host_u.wr(rows[i].wa, rows[i].wd);
            rdc(rows[i].ra, rows[i].m, rows[i].e);
        end
        // abort blocks transfers until the clear bit goes one then zero
        cyc(2);
        chk("permit", o_mst_permit_ff, 32'h1);
        pulse(12);
        chk("permit", o_mst_permit_ff, 32'h0);
        rdc(10'h340, 32'h1, 32'h1);
        host_u.clr_abort(32'h2);
        cyc(2);
        rdc(10'h340, 32'h1, 32'h0);
        chk("permit", o_mst_permit_ff, 32'h1);
        // fifth push into a four-deep queue is dropped, so one pop frees it
        repeat (5) pulse(0);
        rdc(10'h340, 32'h0FFF0000, 32'h00010000);
        pulse(15);
        rdc(10'h340, 32'h0FFF0000, 32'h0);
        pulse(0);
        repeat (4) pulse(11);
        rdc(10'h340, 32'h0FFF0000, 32'h08010000);
        host_u.wr(10'h340, 32'h6);
        cyc(2);
        chk("engine reset", o_eng_reset_ff, 32'h1);
        chk("permit", o_mst_permit_ff, 32'h0);
        rdc(10'h340, 32'h0FFF0000, 32'h0);
        host_u.wr(10'h340, 32'h2);
        cyc(2);
        chk("engine reset", o_eng_reset_ff, 32'h0);
        // completion flag is sticky; the mask only gates the line
        pulse(13);
        rdc(10'h340, 32'h4, 32'h4);
        chk("irq", o_irq_ff, 32'h0);
        host_u.wr(10'h341, 32'h4);
        cyc(3);
        chk("irq", o_irq_ff, 32'h1);
        pulse(14);
        cyc(2);
        rdc(10'h340, 32'h4, 32'h0);
        chk("irq", o_irq_ff, 32'h0);
        host_u.wr(10'h341, 32'hC);
        cyc(3);
        chk("pin drive", {o_inta_n_oe_ff, o_inta_n_o_ff}, 32'h2);
        host_u.isr_clear(32'h4);
        cyc(3);
        chk("irq", o_irq_ff, 32'h0);
        i_fifo_rd_int = 6'h04;
        cyc(4);
        rdc(10'h340, 32'hFFF0, 32'h1000);
        chk("irq", o_irq_ff, 32'h1);
        i_fifo_rd_int = 6'h00;
        i_fifo_wr_int = 6'h20;
        cyc(4);
        rdc(10'h340, 32'hFFF0, 32'h0200);
        i_fifo_wr_int = 6'h00;
        // config pin released: bit 27 follows it after the synchroniser settles
        i_config_n = 1'h1;
        cyc(5);
        rdc(10'h380, 32'hFE000000, 32'h98000000);
        // second reset in mid-run clears both words
        i_rstn = 1'h0;
        cyc(2);
        i_rstn = 1'h1;
        cyc(2);
        rdc(10'h340, 32'hF, 32'h0);
        rdc(10'h341, 32'hFFFFFFFF, 32'h0);
        chk("irq", o_irq_ff, 32'h0);
        end_of_test();
    end
endmodule
